// file: tb/ram_alarm_asserts.sv
// port checker for the alarm block
`timescale 1ns/1ps
`default_nettype none
module ram_alarm_asserts
  import ram_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
)
(
  input wire logic mclk_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire ram_time_t time_i, // running time
  input wire logic sec_tick_i, // seconds tick
  input wire logic on_backup_i, // backup pin
  input wire ram_req_t req_i, // register request
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic reg_blocked_o, // access refused
  input wire logic irq_freq_out_n_o, // pin level
  input wire logic irq_freq_out_oe_o // pin drive
);
  logic [7:0] ctl_q;
  logic leg_q;
  int run_q;
  logic ok;
  logic clr;
  assign ok = req_i.wr && !reg_blocked_o;
  assign clr = ok && req_i.addr == ADDR_STATUS && req_i.wdata[STAT_AL0_BIT];
  // shadows of the mode bits, so no peeking into the body is needed
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ctl_q <= 8'h00;
      leg_q <= 1'b0;
    end
    else if (ok && req_i.addr == ADDR_INTERRUPT_CONTROL)
      ctl_q <= req_i.wdata;
    else if (ok && req_i.addr == ADDR_POWER_CONTROL)
      leg_q <= req_i.wdata[PWR_LEGACY_BIT];
  end
  // length of the current low stretch on the pin
  always_ff @(posedge mclk_i)
    run_q <= irq_freq_out_oe_o ? run_q + 1 : 0;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // a clear with no match in the same cycle must free the single-event pin
  property p_pin;
    clr && !ctl_q[INT_MODE_BIT] && !$past(sec_tick_i) |=> !irq_freq_out_oe_o && irq_freq_out_n_o;
  endproperty
  a_pin: assert property (p_pin) else $error("single irq not released by clear");
  property p_rise; $rose(irq_freq_out_oe_o) |-> $past(sec_tick_i, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq not two cycles after tick");
  property p_off; $rose(irq_freq_out_oe_o) |-> $past(ctl_q[INT_ALARM_ZERO_ENABLE_BIT]); endproperty
  a_off: assert property (p_off) else $error("irq while alarm disabled");
  property p_hold; irq_freq_out_oe_o && !ctl_q[INT_MODE_BIT] && !clr |=> irq_freq_out_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("single irq released early");
  property p_pulse; $fell(irq_freq_out_oe_o) && ctl_q[INT_MODE_BIT] |-> run_q == PULSE_CYCLES;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");
  property p_std; $rose(irq_freq_out_oe_o) && !leg_q |-> !$past(reg_blocked_o); endproperty
  a_std: assert property (p_std) else $error("alarm on standard backup");
  property p_free; !on_backup_i [*5] |-> !reg_blocked_o; endproperty
  a_free: assert property (p_free) else $error("blocked on main power");
  property p_keep; reg_blocked_o && req_i.rd |=> $stable(reg_rdata_o); endproperty
  a_keep: assert property (p_keep) else $error("blocked read changed data");
endmodule
bind ram_alarm ram_alarm_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .time_i(time_i), .sec_tick_i(sec_tick_i), .on_backup_i(on_backup_i),
  .req_i(req_i), .reg_rdata_o(reg_rdata_o), .reg_blocked_o(reg_blocked_o),
  .irq_freq_out_n_o(irq_freq_out_n_o), .irq_freq_out_oe_o(irq_freq_out_oe_o));
`default_nettype wire

// file: tb/ram_host.sv
// host model on the register port
`timescale 1ns/1ps
`default_nettype none
module ram_host
  import ram_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic [7:0] rdata_i, // read data
  output var ram_req_t req_o = '0 // register request
);
  // one byte per request; released fields show inverted junk, not the old value
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge mclk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge mclk_i);
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the alarm block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ram_pkg::*;
  typedef struct { logic [3:0] a; logic [7:0] d; logic [7:0] e; } ram_row_t;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  ram_time_t now = '0;
  logic tick = 1'b0;
  logic bak = 1'b0;
  ram_req_t req;
  logic [7:0] rdata;
  logic blocked;
  logic irq_n;
  logic oe;
  logic [7:0] q;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  localparam ram_time_t HIT = 48'h03_01_01_11_30_00;
  // bit 7 enables a field; disabled fields read back as written
  ram_row_t rows[8] = '{'{4'h0, 8'h00, 8'h00}, '{4'h1, 8'hB0, 8'hB0}, '{4'h2, 8'h91, 8'h91},
    '{4'h3, 8'h81, 8'h81}, '{4'h4, 8'h81, 8'h81}, '{4'h5, 8'h00, 8'h00},
    '{ADDR_STATUS, 8'h20, 8'h00}, '{4'hF, 8'hA5, 8'h00}};
  ram_alarm #(.PULSE_CYCLES(5)) i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .time_i(now),
    .sec_tick_i(tick), .on_backup_i(bak), .req_i(req), .reg_rdata_o(rdata),
    .reg_blocked_o(blocked), .irq_freq_out_n_o(irq_n), .irq_freq_out_oe_o(oe));
  ram_host i_host (.mclk_i(mclk_i), .rdata_i(rdata), .req_o(req));
  always #20 mclk_i = ~mclk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    i_host.xfer(1'b0, a, 8'h00, q);
    check(q, e, "read");
  endtask
  // one seconds tick; the pin answers two cycles after the tick is seen
  task automatic sec(input ram_time_t t, input logic e);
    @(posedge mclk_i);
    now <= t;
    tick <= 1'b1;
    @(posedge mclk_i);
    tick <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 check({7'h00, oe}, {7'h00, e}, "irq");
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // cut a hang short; the full run needs well under a thousand cycles
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rdc(ADDR_POWER_CONTROL, 8'h00);
    check({7'h00, irq_n}, 8'h01, "idle");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    $display("register rows done");
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    sec(HIT, 1'b0);
    wr(ADDR_INTERRUPT_CONTROL, 8'h20);
    sec(48'h03_01_01_11_29_59, 1'b0);
    sec(HIT, 1'b1);
    repeat (20) @(posedge mclk_i);
    #1 check({7'h00, oe}, 8'h01, "held");
    rdc(ADDR_STATUS, 8'h20);
    wr(ADDR_STATUS, 8'h20);
    @(posedge mclk_i);
    #1 check({7'h00, irq_n}, 8'h01, "released");
    $display("single event done");
    wr(4'h0, 8'hB0);
    for (int a = 1; a < 5; a++)
      wr(4'(a), 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'hA0);
    sec(48'h00_00_00_00_00_30, 1'b1);
    repeat (5) @(posedge mclk_i);
    #1 check({7'h00, oe}, 8'h00, "pulse end");
    sec(48'h00_00_00_00_01_30, 1'b1);
    repeat (6) @(posedge mclk_i);
    rdc(ADDR_STATUS, 8'h20);
    $display("pulsed done");
    bak <= 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 check({7'h00, blocked}, 8'h01, "blocked");
    sec(48'h00_00_00_00_02_30, 1'b0);
    bak <= 1'b0;
    repeat (6) @(posedge mclk_i);
    wr(ADDR_POWER_CONTROL, 8'h01);
    bak <= 1'b1;
    repeat (6) @(posedge mclk_i);
    sec(48'h00_00_00_00_03_30, 1'b1);
    repeat (6) @(posedge mclk_i);
    wr(ADDR_POWER_CONTROL, 8'h03);
    @(posedge mclk_i);
    #1 check({7'h00, blocked}, 8'h01, "inhibit");
    rdc(ADDR_INTERRUPT_CONTROL, 8'h20);
    bak <= 1'b0;
    $display("backup done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: verilog/ram_alarm.sv
// alarm-zero match, interrupt output and backup-mode gating
`timescale 1ns/1ps
`default_nettype none
module ram_alarm
  import ram_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
)
(
  input wire logic mclk_i, // 25 MHz system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire ram_time_t time_i, // running time, same clock domain
  input wire logic sec_tick_i, // one-cycle pulse: time_i just advanced
  input wire logic on_backup_i, // pin: high while running from backup supply
  input wire ram_req_t req_i, // register access request
  output logic [7:0] reg_rdata_o, // read data, valid the cycle after rd
  output logic reg_blocked_o, // access currently refused
  output logic irq_freq_out_n_o, // open-drain pin level, low when driven
  output logic irq_freq_out_oe_o // high while the pin is pulled low
);
  typedef struct packed {
    logic [NUM_FIELDS-1:0][7:0] alarm;
    logic [7:0] int_ctrl;
    logic [7:0] pwr_ctrl;
    logic al0_flag;
    logic [31:0] pulse_cnt;
    logic eval;
    logic [7:0] rdata;
  } ram_state_t;

  ram_state_t st_q;
  ram_state_t st_d;
  ram_time_t now;
  logic backup;
  logic [NUM_FIELDS-1:0] fld_ok;
  logic functions_on;
  logic access_on;
  logic match;
  logic wr_ok;
  logic rd_ok;
  logic pulsed_mode;
  logic [7:0] rd_mux;

  // backup indication comes from a pin, hence the synchroniser
  ram_pin_sync u_backup_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(on_backup_i),
    .level_o(backup)
  );

  assign now = time_i;

  // per-field compare; every field must pass
  ram_field_cmp u_cmp_sec (.alarm_i(st_q.alarm[0]), .now_i(now.seconds), .ok_o(fld_ok[0]));
  ram_field_cmp u_cmp_min (.alarm_i(st_q.alarm[1]), .now_i(now.minutes), .ok_o(fld_ok[1]));
  ram_field_cmp u_cmp_hr (.alarm_i(st_q.alarm[2]), .now_i(now.hours), .ok_o(fld_ok[2]));
  ram_field_cmp u_cmp_date (.alarm_i(st_q.alarm[3]), .now_i(now.date), .ok_o(fld_ok[3]));
  ram_field_cmp u_cmp_mon (.alarm_i(st_q.alarm[4]), .now_i(now.month), .ok_o(fld_ok[4]));
  ram_field_cmp u_cmp_wday (.alarm_i(st_q.alarm[5]), .now_i(now.weekday), .ok_o(fld_ok[5]));

  // backup gating: standard mode keeps only timekeeping alive
  assign functions_on = !backup || st_q.pwr_ctrl[PWR_LEGACY_BIT];
  // inhibit only bites in legacy backup; standard backup already blocks all
  assign access_on = functions_on
    && !(backup && st_q.pwr_ctrl[PWR_SBI_BIT]);
  assign reg_blocked_o = !access_on;
  assign wr_ok = req_i.wr && access_on;
  assign rd_ok = req_i.rd && access_on;
  assign pulsed_mode = st_q.int_ctrl[INT_MODE_BIT];

  // evaluated one cycle after the tick so the compare sees the new time
  assign match = st_q.eval && (&fld_ok)
    && st_q.int_ctrl[INT_ALARM_ZERO_ENABLE_BIT]
    && functions_on;

  // read data selection
  always_comb
  begin
    rd_mux = 8'h00;
    if (req_i.addr <= ADDR_ALARM0_WEEKDAY)
    begin
      rd_mux = st_q.alarm[req_i.addr[2:0]];
    end
    else if (req_i.addr == ADDR_INTERRUPT_CONTROL)
    begin
      rd_mux = st_q.int_ctrl;
    end
    else if (req_i.addr == ADDR_STATUS)
    begin
      rd_mux[STAT_AL0_BIT] = st_q.al0_flag;
    end
    else if (req_i.addr == ADDR_POWER_CONTROL)
    begin
      rd_mux = st_q.pwr_ctrl;
    end
  end

  // next-state logic
  always_comb
  begin
    st_d = st_q;
    st_d.eval = sec_tick_i;
    if (rd_ok)
    begin
      st_d.rdata = rd_mux;
    end
    if (wr_ok)
    begin
      if (req_i.addr <= ADDR_ALARM0_WEEKDAY)
      begin
        st_d.alarm[req_i.addr[2:0]] = req_i.wdata;
      end
      else if (req_i.addr == ADDR_INTERRUPT_CONTROL)
      begin
        st_d.int_ctrl = req_i.wdata;
      end
      else if (req_i.addr == ADDR_POWER_CONTROL)
      begin
        st_d.pwr_ctrl = req_i.wdata;
      end
      else if (req_i.addr == ADDR_STATUS && req_i.wdata[STAT_AL0_BIT])
      begin
        st_d.al0_flag = 1'b0; // write one to clear
      end
    end
    // pulse countdown runs independently of the flag
    if (st_q.pulse_cnt != 32'h0)
    begin
      st_d.pulse_cnt = st_q.pulse_cnt - 32'h1;
    end
    // a match in the clearing cycle wins over the clear
    if (match)
    begin
      st_d.al0_flag = 1'b1;
      if (pulsed_mode)
      begin
        st_d.pulse_cnt = 32'(PULSE_CYCLES);
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_q.alarm <= {NUM_FIELDS{RST_ALARM}};
      st_q.int_ctrl <= RST_INT_CTRL;
      st_q.pwr_ctrl <= RST_PWR_CTRL; // standard mode after reset
      st_q.al0_flag <= 1'b0;
      st_q.pulse_cnt <= 32'h0;
      st_q.eval <= 1'b0;
      st_q.rdata <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // single-event holds the pin low on the flag; pulsed mode on the counter
  // the pin stays active on backup in every mode, it only sees what fired
  always_comb
  begin
    if (pulsed_mode)
    begin
      irq_freq_out_oe_o = st_q.pulse_cnt != 32'h0;
    end
    else
    begin
      irq_freq_out_oe_o = st_q.al0_flag;
    end
  end

  assign irq_freq_out_n_o = !irq_freq_out_oe_o;
  assign reg_rdata_o = st_q.rdata;
endmodule
`default_nettype wire

// file: verilog/ram_field_cmp.sv
// one alarm field compared against the running time
`timescale 1ns/1ps
`default_nettype none
module ram_field_cmp
  import ram_pkg::*;
(
  input wire logic [7:0] alarm_i, // alarm register: enable and target
  input wire logic [7:0] now_i, // current time field
  output logic ok_o // field does not block a match
);
  // a disabled field always passes, so it neither blocks nor causes a match
  assign ok_o = !alarm_i[FLD_ENABLE_BIT]
    || (alarm_i[FLD_ENABLE_BIT-1:0] == now_i[FLD_ENABLE_BIT-1:0]);
endmodule
`default_nettype wire

// file: verilog/ram_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ram_pin_sync
  import ram_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic pin_i, // asynchronous pin
  output logic level_o // filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ram_sync_st_t;

  ram_sync_st_t st_q;
  ram_sync_st_t st_d;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule
`default_nettype wire

// file: verilog/ram_pkg.sv
// constants, types and register map of the alarm-match block
// Summary of operation
// - alarm field bit 7 enables the field; lower bits hold its target value.
// - a field with its enable bit clear never blocks nor causes a match.
// - matches are ignored unless alarm-zero enable, control bit 5, is set.
// - control bit 7 picks single-event (0) or pulsed repeating (1) interrupt.
// - single-event match after the seconds roll sets the flag, drives irq low.
// - pulsed mode emits one irq pulse on every match of the enabled fields.
// - pulsed mode sets the flag each trigger; pulses continue if never cleared.
// - standard backup mode stops alarms and register access while on backup.
// - legacy backup keeps alarms, and keeps access unless serial bus inhibit is 1.
// - after reset the device is in standard backup mode.
package ram_pkg;
  localparam int REG_AW = 4;
  localparam int NUM_FIELDS = 6;
  // register indices on the register port
  localparam logic [3:0] ADDR_ALARM0_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_ALARM0_MINUTES = 4'h1;
  localparam logic [3:0] ADDR_ALARM0_HOURS = 4'h2;
  localparam logic [3:0] ADDR_ALARM0_DATE = 4'h3;
  localparam logic [3:0] ADDR_ALARM0_MONTH = 4'h4;
  localparam logic [3:0] ADDR_ALARM0_WEEKDAY = 4'h5;
  localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_POWER_CONTROL = 4'h8;
  // field positions
  localparam int FLD_ENABLE_BIT = 7;
  localparam int INT_MODE_BIT = 7;
  localparam int INT_ALARM_ZERO_ENABLE_BIT = 5;
  localparam int STAT_AL0_BIT = 5;
  localparam int PWR_LEGACY_BIT = 0;
  localparam int PWR_SBI_BIT = 1;
  // reset values
  localparam logic [7:0] RST_ALARM = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int PULSE_MS = 250;
  localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;

  // running time as presented by the timekeeping counters
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } ram_time_t;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [7:0] wdata;
  } ram_req_t;
endpackage
